// *** rtl/adc_wport_defs.svh ***
// Named constants of the converter register write port
`ifndef ADC_WPORT_DEFS_SVH
`define ADC_WPORT_DEFS_SVH

// ****************************************************************
// Word layout on the shared data bus
// ****************************************************************
`define DATA_W             10
`define ADDR_HI            9
`define ADDR_LO            8
`define SEL_CLAMP_LOW      2'h0
`define SEL_CLAMP_HIGH     2'h1
`define SEL_CONTROL        2'h2
`define SEL_TEST           2'h3

// ****************************************************************
// Field positions
// ****************************************************************
`define CLAMP_LOW_HI       7
`define CLAMP_HIGH_HI      1
`define TEST_HI            7
`define CTRL_CLAMP_OFF     6
`define CTRL_CODING        5
`define CTRL_SOURCE        4
`define CTRL_POWER_DOWN    3
`define CTRL_GAIN_HI       2

// ****************************************************************
// Reset values
// ****************************************************************
`define CLAMP_LOW_DEFAULT  8'h00
`define CLAMP_HIGH_DEFAULT 2'h0
`define TEST_DEFAULT       8'h00
`define GAIN_DEFAULT       3'h1
`define DATA_OUT_DEFAULT   10'h000

// ****************************************************************
// Timing and coding
// ****************************************************************
`define CLK_PERIOD_NS      25
`define WAKE_TIME_NS       400
`define WAKE_CNT_W         5
`define WAKE_CYCLES        (`WAKE_TIME_NS / `CLK_PERIOD_NS)
`define TWOS_FLIP          10'h200

`endif

// *** rtl/adc_wport_pkg.sv ***
// Types shared by the converter register write port
`include "adc_wport_defs.svh"

package adc_wport_pkg;

    // Power sequence: run, sleep, wake, with Gray steps on the way down
    typedef enum logic [1:0] {
        PWR_RUN   = 2'h0,
        PWR_SLEEP = 2'h1,
        PWR_WAKE  = 2'h3
    } power_state_t;

    // State of the write port apart from its sample FIFO
    typedef struct packed {
        logic                      wr_n_q;
        logic [`CLAMP_LOW_HI:0]    clamp_low;
        logic [`CLAMP_HIGH_HI:0]   clamp_high;
        logic                      clamp_off;
        logic                      coding;
        logic                      source;
        logic                      power_down;
        logic [`CTRL_GAIN_HI:0]    gain;
        logic [`TEST_HI:0]         test;
        power_state_t              pwr;
        logic [`WAKE_CNT_W-1:0]    wake_cnt;
        logic [`DATA_W-1:0]        data_out;
        logic                      data_valid;
    } port_state_t;

    localparam port_state_t PORT_RESET = '{
        wr_n_q:     1'b1,
        clamp_low:  `CLAMP_LOW_DEFAULT,
        clamp_high: `CLAMP_HIGH_DEFAULT,
        clamp_off:  1'b0,
        coding:     1'b0,
        source:     1'b0,
        power_down: 1'b0,
        gain:       `GAIN_DEFAULT,
        test:       `TEST_DEFAULT,
        pwr:        PWR_RUN,
        wake_cnt:   '0,
        data_out:   `DATA_OUT_DEFAULT,
        data_valid: 1'b0
    };

endpackage : adc_wport_pkg

// *** rtl/fifo_store.sv ***
// Word store of the sample FIFO with registered, write-first read
`timescale 1ns/1ps
`default_nettype none

module fifo_store #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 32,
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             we,
    input  wire logic [AW-1:0]    waddr,
    input  wire logic [WIDTH-1:0] wdata,
    input  wire logic [AW-1:0]    raddr,
    output logic      [WIDTH-1:0] rdata
);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] words;
        logic [WIDTH-1:0]            rdata;
    } store_state_t;

    store_state_t s_reg;
    store_state_t s_next;

    // Bypass on a colliding address so a word written into an
    // empty FIFO is visible one edge later
    always_comb begin
        s_next = s_reg;
        if (we) begin
            s_next.words[waddr] = wdata;
        end
        if (we && (waddr == raddr)) begin
            s_next.rdata = wdata;
        end else begin
            s_next.rdata = s_reg.words[raddr];
        end
    end

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign rdata = s_reg.rdata;

endmodule : fifo_store

`default_nettype wire

// *** rtl/sample_fifo.sv ***
// Sample FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none

module sample_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 32
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    // Depth must be a power of two so the pointers wrap by themselves
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [CW-1:0] count;
    } fifo_state_t;

    fifo_state_t s_reg;
    fifo_state_t s_next;
    logic        push;
    logic        pop;

    // Handshakes from the registered fill count
    assign in_ready  = (s_reg.count != FULL_COUNT);
    assign out_valid = (s_reg.count != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Pointer and count update
    always_comb begin
        s_next = s_reg;
        if (push) begin
            s_next.wr_ptr = s_reg.wr_ptr + 1'b1;
        end
        if (pop) begin
            s_next.rd_ptr = s_reg.rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            s_next.count = s_reg.count + 1'b1;
        end else if (pop && !push) begin
            s_next.count = s_reg.count - 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // Read ahead at the next read pointer so out_data is the head word
    fifo_store #(
        .WIDTH (WIDTH),
        .DEPTH (DEPTH),
        .AW    (AW)
    ) u_store (
        .clk   (clk),
        .rst_n (rst_n),
        .we    (push),
        .waddr (s_reg.wr_ptr),
        .wdata (in_data),
        .raddr (s_next.rd_ptr),
        .rdata (out_data)
    );

endmodule : sample_fifo

`default_nettype wire

// *** rtl/adc_register_write_port.sv ***
// Register write port, configuration and sample output of the converter
//
// Overview of operation
// - Four registers exist: low clamp, high clamp, control and a reserved test register.
// - While a write is under way the sample output bus is not driven.
// - Word bits 9:8 select low clamp, high clamp, control or test register.
// - Bits 7:0 of a low clamp write become clamp code bits 7:0.
// - Bits 1:0 of a high clamp write become clamp code bits 9:8, default 00, bits 7:2 ignored.
// - The 10-bit clamp level joins the quarter select with the 256-step level inside it.
// - Control bit 6, default 0, disables the clamp amplifier when set.
// - Control bit 5 selects straight binary (0, default) or two's complement output.
// - Control bit 4 selects external clamp input (0, default) or internal clamp converter.
// - Control bit 3, default 0, powers the whole converter down when set.
// - Control bits 2:0 hold the gain code, default 001, steps of 0.5 from 0.5 to 4.0.
// - With output enable high the data outputs are high impedance.
// - After power down is cleared the converter runs again within 400 ns.
`timescale 1ns/1ps
`default_nettype none
`include "adc_wport_defs.svh"

module adc_register_write_port #(
    parameter int FIFO_DEPTH = 32
) (
    input  wire logic               clk,
    input  wire logic               rst_n,
    // Shared data bus pin, split into its three signals
    input  wire logic [`DATA_W-1:0] shared_data_in,
    output logic      [`DATA_W-1:0] shared_data_out,
    output logic                    shared_data_oe_n,
    // Host strobes
    input  wire logic               oe_n,
    input  wire logic               wr_n,
    // Straight binary samples from the converter core
    input  wire logic               sample_valid,
    output logic                    sample_ready,
    input  wire logic [`DATA_W-1:0] sample_data,
    // Marks a new word on shared_data_out
    output logic                    out_valid,
    // Configuration towards the analog section
    output logic      [`DATA_W-1:0] clamp_level,
    output logic                    clamp_amp_disable,
    output logic                    clamp_source_select,
    output logic                    output_coding_select,
    output logic                    power_down,
    output logic [`CTRL_GAIN_HI:0]  gain_code,
    output logic [`TEST_HI:0]       factory_test_bits,
    output logic                    converter_ready
);

    // ****************************************************************
    // State and local signals
    // ****************************************************************
    adc_wport_pkg::port_state_t s_reg;
    adc_wport_pkg::port_state_t s_next;

    logic               wr_rise;
    logic               write_busy;
    logic               drive_bus;
    logic               running;
    logic               fifo_in_ready;
    logic               fifo_out_valid;
    logic               fifo_pop;
    logic [`DATA_W-1:0] fifo_out_data;
    logic [`DATA_W-1:0] coded_sample;
    logic [1:0]         sel;

    // ****************************************************************
    // Strobe decode
    // ****************************************************************
    // rising strobe edge
    assign wr_rise = !s_reg.wr_n_q && wr_n;
    assign sel = shared_data_in[`ADDR_HI:`ADDR_LO];

    // bus released from strobe fall until after its rise
    assign write_busy = !wr_n || !s_reg.wr_n_q;
    // output enable high keeps the pins floating
    assign drive_bus = !oe_n && !write_busy;
    assign shared_data_oe_n = !drive_bus;

    // ****************************************************************
    // Sample path
    // ****************************************************************
    // Samples stall while asleep, so the core sees back-pressure
    assign running      = (s_reg.pwr == adc_wport_pkg::PWR_RUN);
    assign sample_ready = fifo_in_ready && running;
    assign fifo_pop     = fifo_out_valid && drive_bus;

    // two's complement is straight binary with the sign bit flipped
    assign coded_sample = s_reg.coding ? (fifo_out_data ^ `TWOS_FLIP)
                                       : fifo_out_data;

    // Buffer decouples the core from pauses while the host writes
    sample_fifo #(
        .WIDTH (`DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_valid  (sample_valid && running),
        .in_ready  (fifo_in_ready),
        .in_data   (sample_data),
        .out_valid (fifo_out_valid),
        .out_ready (drive_bus),
        .out_data  (fifo_out_data)
    );

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        s_next = s_reg;
        s_next.wr_n_q = wr_n;
        s_next.data_valid = fifo_pop;

        // Output word holds between pops, so a paused bus keeps its value
        if (fifo_pop) begin
            s_next.data_out = coded_sample;
        end

        // load only on the strobe edge, with output enable low
        if (wr_rise && !oe_n) begin
            case (sel)
                `SEL_CLAMP_LOW: begin
                    s_next.clamp_low = shared_data_in[`CLAMP_LOW_HI:0];
                end
                `SEL_CLAMP_HIGH: begin
                    s_next.clamp_high = shared_data_in[`CLAMP_HIGH_HI:0];
                end
                `SEL_CONTROL: begin
                    s_next.clamp_off  = shared_data_in[`CTRL_CLAMP_OFF];
                    s_next.coding     = shared_data_in[`CTRL_CODING];
                    s_next.source     = shared_data_in[`CTRL_SOURCE];
                    s_next.power_down = shared_data_in[`CTRL_POWER_DOWN];
                    s_next.gain       = shared_data_in[`CTRL_GAIN_HI:0];
                end
                `SEL_TEST: begin
                    // reserved register is stored but steers nothing
                    s_next.test = shared_data_in[`TEST_HI:0];
                end
                default: begin
                    s_next.test = s_reg.test;
                end
            endcase
        end

        // wake count bounds the restart after power down clears
        case (s_reg.pwr)
            adc_wport_pkg::PWR_RUN: begin
                if (s_reg.power_down) begin
                    s_next.pwr = adc_wport_pkg::PWR_SLEEP;
                end
            end
            adc_wport_pkg::PWR_SLEEP: begin
                if (!s_reg.power_down) begin
                    s_next.pwr = adc_wport_pkg::PWR_WAKE;
                    s_next.wake_cnt = `WAKE_CNT_W'(`WAKE_CYCLES - 2);
                end
            end
            adc_wport_pkg::PWR_WAKE: begin
                if (s_reg.power_down) begin
                    s_next.pwr = adc_wport_pkg::PWR_SLEEP;
                end else if (s_reg.wake_cnt == '0) begin
                    s_next.pwr = adc_wport_pkg::PWR_RUN;
                end else begin
                    s_next.wake_cnt = s_reg.wake_cnt - 1'b1;
                end
            end
            default: begin
                s_next.pwr = adc_wport_pkg::PWR_RUN;
            end
        endcase
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    // defaults at reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= adc_wport_pkg::PORT_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // quarter select above the 256-step level
    assign clamp_level          = {s_reg.clamp_high, s_reg.clamp_low};
    assign clamp_amp_disable    = s_reg.clamp_off;
    assign clamp_source_select  = s_reg.source;
    assign output_coding_select = s_reg.coding;
    assign power_down           = s_reg.power_down;
    assign gain_code            = s_reg.gain;
    assign factory_test_bits    = s_reg.test;
    assign converter_ready      = running;
    assign shared_data_out      = s_reg.data_out;
    assign out_valid            = s_reg.data_valid;

endmodule : adc_register_write_port

`default_nettype wire

// *** dv/host_model.sv ***
// Host controller model: drives the shared bus and the write strobes
`timescale 1ns/1ps
`default_nettype none

module host_model (
    input  wire logic       clk,
    input  wire logic [9:0] dev_data,
    input  wire logic       dev_oe_n,
    output logic      [9:0] bus,
    output logic            oe_n,
    output logic            wr_n
);
    logic       drv;
    logic [9:0] word;
    logic [9:0] last;

    // strobes idle high; this host never opens a clamp interval
    initial begin
        drv = 1'b0;
        word = 10'h000;
        oe_n = 1'b1;
        wr_n = 1'b1;
        last = 10'h000;
    end

    // Undriven bus shows a value that changes every cycle, never a stale one
    assign bus = drv ? word : (!dev_oe_n ? dev_data : ~last);
    always @(posedge clk) begin
        last <= bus;
    end

    task write_word(input logic [9:0] w, input logic oe);
        @(posedge clk);
        oe_n <= oe;
        wr_n <= 1'b0;
        drv <= 1'b1;
        word <= w;
        @(posedge clk);
        wr_n <= 1'b1;
        @(posedge clk);
        drv <= 1'b0;
    endtask : write_word

    // Host side output enable, also used to stall the sample drain
    task set_oe(input logic v);
        @(posedge clk);
        oe_n <= v;
    endtask : set_oe
endmodule : host_model

`default_nettype wire

// *** dv/adc_register_write_port_assertions.sv ***
// Concurrent checks on the converter register write port
`timescale 1ns/1ps
`default_nettype none
`include "adc_wport_defs.svh"

module adc_wport_checker #(
    parameter int FIFO_DEPTH = 32
) (
    input wire logic                  clk,
    input wire logic                  rst_n,
    input wire logic [`DATA_W-1:0]    shared_data_in,
    input wire logic                  shared_data_oe_n,
    input wire logic                  oe_n,
    input wire logic                  wr_n,
    input wire logic                  sample_ready,
    input wire logic [`DATA_W-1:0]    clamp_level,
    input wire logic                  clamp_amp_disable,
    input wire logic                  clamp_source_select,
    input wire logic                  output_coding_select,
    input wire logic                  power_down,
    input wire logic [`CTRL_GAIN_HI:0] gain_code,
    input wire logic [`TEST_HI:0]     factory_test_bits,
    input wire logic                  converter_ready
);
    logic       wr_q;
    logic       take;
    logic [1:0] sel;
    logic [6:0] cfg;

    // Strobe history, so a rise can be seen
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q <= 1'b1;
        end else begin
            wr_q <= wr_n;
        end
    end
    assign take = !wr_q && wr_n && !oe_n;
    assign sel = shared_data_in[9:8];
    assign cfg = {clamp_amp_disable, output_coding_select,
                  clamp_source_select, power_down, gain_code};

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_oe_release; oe_n |-> shared_data_oe_n; endproperty
    a_oe_release: assert property (p_oe_release)
        else $error("bus driven while oe_n high");
    property p_wr_release; (!wr_n || !wr_q) |-> shared_data_oe_n; endproperty
    a_wr_release: assert property (p_wr_release)
        else $error("bus driven during a write");
    property p_low; take && sel == 2'h0 |=> clamp_level[7:0] ==
        $past(shared_data_in[7:0]) && $stable(clamp_level[9:8]); endproperty
    a_low: assert property (p_low)
        else $error("low clamp write lost");
    property p_high; take && sel == 2'h1 |=> clamp_level[9:8] ==
        $past(shared_data_in[1:0]) && $stable(clamp_level[7:0]); endproperty
    a_high: assert property (p_high)
        else $error("high clamp write lost");
    property p_ctrl; take && sel == 2'h2 |=>
        cfg == $past(shared_data_in[6:0]); endproperty
    a_ctrl: assert property (p_ctrl)
        else $error("control write lost");
    property p_test; take && sel == 2'h3 |=> $stable(cfg) && $stable(clamp_level)
        && factory_test_bits == $past(shared_data_in[7:0]); endproperty
    a_test: assert property (p_test)
        else $error("test write touched other fields");
    property p_hold; !take |=> $stable(cfg) && $stable(clamp_level)
        && $stable(factory_test_bits); endproperty
    a_hold: assert property (p_hold)
        else $error("register changed without a strobe rise");
    property p_sleep; power_down |=> !converter_ready && !sample_ready;
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("converter still running while powered down");
    property p_wake; $fell(power_down) |-> ##[1:16] converter_ready;
    endproperty
    a_wake: assert property (p_wake)
        else $error("wake took longer than 16 cycles");
endmodule : adc_wport_checker

bind adc_register_write_port adc_wport_checker #(
    .FIFO_DEPTH(FIFO_DEPTH)
) chk_inst (
    .clk(clk), .rst_n(rst_n), .shared_data_in(shared_data_in),
    .shared_data_oe_n(shared_data_oe_n), .oe_n(oe_n), .wr_n(wr_n),
    .sample_ready(sample_ready), .clamp_level(clamp_level),
    .clamp_amp_disable(clamp_amp_disable),
    .clamp_source_select(clamp_source_select),
    .output_coding_select(output_coding_select), .power_down(power_down),
    .gain_code(gain_code), .factory_test_bits(factory_test_bits),
    .converter_ready(converter_ready)
);

`default_nettype wire

// *** dv/adc_register_write_port_bench.sv ***
// Self-checking bench of the converter register write port
`timescale 1ns/1ps
`default_nettype none
`include "adc_wport_defs.svh"

module adc_register_write_port_bench;
    localparam int DEPTH = 32;
    logic       clk, rst_n, sample_valid, sample_ready, out_valid;
    logic       dout_oe_n, oe_n, wr_n, amp, src, cod, pd, crdy;
    logic [9:0] sample_data, bus, dout, clamp_level, e_clamp;
    logic [2:0] gain;
    logic [7:0] tbits, e_test;
    logic [6:0] e_ctrl;
    logic [9:0] expq[$];
    int         failures, samples_checked, n, seed;

    always #12.5 clk = ~clk;

    adc_register_write_port #(.FIFO_DEPTH(DEPTH)) adc_register_write_port_inst (
        .clk(clk), .rst_n(rst_n), .shared_data_in(bus),
        .shared_data_out(dout), .shared_data_oe_n(dout_oe_n),
        .oe_n(oe_n), .wr_n(wr_n), .sample_valid(sample_valid),
        .sample_ready(sample_ready), .sample_data(sample_data),
        .out_valid(out_valid), .clamp_level(clamp_level),
        .clamp_amp_disable(amp), .clamp_source_select(src),
        .output_coding_select(cod), .power_down(pd), .gain_code(gain),
        .factory_test_bits(tbits), .converter_ready(crdy));

    host_model host_model_inst (.clk(clk), .dev_data(dout),
        .dev_oe_n(dout_oe_n), .bus(bus), .oe_n(oe_n), .wr_n(wr_n));

    task check(input logic [9:0] seen, input logic [9:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task check_cfg;
        @(negedge clk);
        check(clamp_level, e_clamp);
        check({3'h0, amp, cod, src, pd, gain}, {3'h0, e_ctrl});
        check({2'h0, tbits}, {2'h0, e_test});
    endtask : check_cfg

    task wr(input logic [9:0] w, input logic oe);
        host_model_inst.write_word(w, oe);
        if (!oe) begin
            case (w[9:8])
                2'h0: e_clamp[7:0] = w[7:0];
                2'h1: e_clamp[9:8] = w[1:0];
                2'h2: e_ctrl = w[6:0];
                default: e_test = w[7:0];
            endcase
        end
        check_cfg();
    endtask : wr

    // Offers random samples; stops at the first refusal
    task push(input int cnt, output int got);
        got = 0;
        while (got < cnt) begin
            @(posedge clk);
            sample_valid <= 1'b1;
            sample_data <= 10'($urandom);
            @(negedge clk);
            if (sample_ready !== 1'b1) break;
            expq.push_back(sample_data ^ (cod ? `TWOS_FLIP : 10'h000));
            got++;
        end
        @(posedge clk);
        sample_valid <= 1'b0;
    endtask : push

    task drain;
        for (int i = 0; i < 200 && expq.size() != 0; i++) @(posedge clk);
        check(10'(expq.size()), 10'h000);
    endtask : drain

    // Each output word is matched against the oldest expected sample
    always @(negedge clk) begin
        if (rst_n === 1'b1 && out_valid === 1'b1) begin
            check(dout, expq.size() != 0 ? expq.pop_front() : ~dout);
        end
    end

    task print_verdict;
        $display("checked %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : print_verdict

    // Whole run is a few hundred cycles; this cuts a hang short
    initial begin
        #(20000 * 25);
        failures++;
        print_verdict();
    end

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        sample_valid = 1'b0;
        sample_data = 10'h000;
        failures = 0;
        samples_checked = 0;
        e_clamp = 10'h000;
        e_ctrl = 7'h01;
        e_test = 8'h00;
        seed = $urandom(98467);
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        check_cfg();
        check({9'h000, crdy}, 10'h001);
        $display("test defaults done");
        // Power-down bit kept clear here; it has its own test
        for (int i = 0; i < 48; i++) begin
            wr({2'(i), 8'($urandom)} & ((i % 4 == 2) ? 10'h3F7 : 10'h3FF), 1'b0);
        end
        for (int g = 0; g < 8; g++) wr({2'h2, 5'h00, 3'(g)}, 1'b0);
        wr(10'h0A5, 1'b1);
        $display("test register writes done");
        wr(10'h208, 1'b0);
        repeat (2) @(posedge clk);
        push(1, n);
        check(10'(n), 10'h000);
        check({9'h000, crdy}, 10'h000);
        wr(10'h200, 1'b0);
        n = 0;
        while (crdy !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        check(10'(n <= `WAKE_CYCLES), 10'h001);
        $display("test power down done");
        host_model_inst.set_oe(1'b1);
        push(DEPTH + 8, n);
        check(10'(n), 10'(DEPTH));
        host_model_inst.set_oe(1'b0);
        drain();
        wr(10'h223, 1'b0);
        push(8, n);
        drain();
        $display("test sample path done");
        print_verdict();
    end
endmodule : adc_register_write_port_bench

`default_nettype wire
